// >>> verilog/bro_consts.vh
`ifndef BRO_CONSTS_VH
`define BRO_CONSTS_VH

// capacity of one embedded block memory, parity bits included
`define BRO_BLOCK_BITS      18432

// register byte offsets
`define BRO_OFS_CTRL        8'h00
`define BRO_OFS_STATUS      8'h04
`define BRO_OFS_LOADADDR    8'h08
`define BRO_OFS_LOADLO      8'h0C
`define BRO_OFS_LOADHI      8'h10
`define BRO_OFS_READCNT     8'h14
`define BRO_OFS_LASTLO      8'h18
`define BRO_OFS_LASTHI      8'h1C
`define BRO_OFS_LASTADDR    8'h20

// control fields
`define BRO_CTRL_LOCK       0
`define BRO_CTRL_AUTOINC    1
`define BRO_CTRL_RESET      2'h2

// status fields
`define BRO_ST_LOCK         0
`define BRO_ST_REGISTERED_OUTPUT       1
`define BRO_ST_SYNC         2
`define BRO_ST_GSREN        3
`define BRO_ST_GSRACT       4
`define BRO_ST_LASTHIT      5
`define BRO_ST_BANK_LSB     8
`define BRO_ST_DEPTHB_LSB   12
`define BRO_ST_WIDTHB_LSB   16

// reset values
`define BRO_LOADADDR_RESET  32'h00000000
`define BRO_LOADHI_RESET    32'h00000000
`define BRO_READCNT_RESET   32'h00000000

`endif

// >>> verilog/bro_ebr.v
module bro_ebr #(
	parameter       DATA_W    = 1,
	parameter       ADDR_W    = 14,
	parameter [2:0] BANK_CODE = 3'h0,
	parameter       OUT_REG   = 0
) (
	input  wire              mclk,
	input  wire              rstN,
	input  wire              syncClr,
	input  wire              clkGate,
	input  wire [ADDR_W-1:0] location,
	input  wire [2:0]        bankSel,
	input  wire              loadEn,
	input  wire [ADDR_W-1:0] loadAddr,
	input  wire [DATA_W-1:0] loadData,
	output wire [DATA_W-1:0] readWord,
	output wire              hit
);

	localparam DEPTH = 1 << ADDR_W;

	reg  [DATA_W-1:0] mem [0:DEPTH-1];
	reg  [ADDR_W-1:0] addrReg;
	reg               selReg;
	reg  [DATA_W-1:0] registered_output;
	wire [DATA_W-1:0] arrayWord;

	assign hit = (bankSel == BANK_CODE);

	// preload port, untouched by any reset
	always @(posedge mclk) begin
		if (loadEn) begin
			mem[loadAddr] <= loadData;
		end
	end

	// input register in front of the array
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			addrReg <= {ADDR_W{1'b0}};
			selReg  <= 1'b0;
		end else if (syncClr) begin
			addrReg <= {ADDR_W{1'b0}};
			selReg  <= 1'b0;
		end else if (clkGate) begin
			addrReg <= location;
			selReg  <= hit;
		end
	end

	assign arrayWord = selReg ? mem[addrReg] : {DATA_W{1'b0}};

	// optional output register
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			registered_output <= {DATA_W{1'b0}};
		end else if (syncClr) begin
			registered_output <= {DATA_W{1'b0}};
		end else if (clkGate) begin
			registered_output <= arrayWord;
		end
	end

	assign readWord = (OUT_REG != 0) ? registered_output : arrayWord;

endmodule // bro_ebr

// >>> verilog/bro_rom.v
`include "bro_consts.vh"

// Behaviour
// - read location is captured into an input register; array reads only that register
// - output stage unregistered by default, optionally registered after the array
// - reset clears only address and output registers, never memory contents
// - in depth cascade the 3-bit bank select acts as top address bits
// - each block answers only when bank select equals its fixed 3-bit code
// - each block stores 16,384 bits from 16Kx1 to 4Kx4, and 18,432 bits, parity bits included, from 2Kx9 to 512x36
// - organisations 16Kx1 to 512x36, location width 14 down to 9 bits
// - depths 16K down to 512 words; address width follows the depth
// - reset acts asynchronously by default, or synchronously on next edge
// - a setting decides if chip-wide set/reset clears the registers; default on
// - contents preloaded through the load registers and returned unchanged
// - small ROM fits one block; larger ones cascade in depth and width
module bro_rom #(
	parameter       DATA_W       = 1,
	parameter       DEPTH        = 16384,
	parameter       DEPTH_BLOCKS = 1,
	parameter       WIDTH_BLOCKS = 1,
	parameter       OUT_REG      = 0,
	parameter       SYNC_RESET   = 0,
	parameter       GSR_ENABLE   = 1,
	parameter [2:0] BANK_CODE    = 3'h0,
	parameter       APB_AW       = 8
) (
	input  wire                         mclk,
	input  wire                         reset_n,
	input  wire [clog2(DEPTH)-1:0]      locationBus,
	input  wire [2:0]                   bankSelect,
	input  wire                         outputClockGate,
	input  wire                         romReset,
	input  wire                         chipwideSetReset,
	output wire [DATA_W*WIDTH_BLOCKS-1:0] readWord,
	input  wire                         psel,
	input  wire                         penable,
	input  wire                         pwrite,
	input  wire [APB_AW-1:0]            paddr,
	input  wire [31:0]                  pwdata,
	input  wire [3:0]                   pstrb,
	output reg  [31:0]                  prdata,
	output wire                         pready,
	output wire                         pslverr
);

	// ceiling log2
	function integer clog2;
		input integer value;
		integer v;
		begin
			v = value - 1;
			clog2 = 0;
			while (v > 0) begin
				clog2 = clog2 + 1;
				v = v >> 1;
			end
		end
	endfunction

	// location width of one block for a given organisation
	function integer orgAddrW;
		input integer width;
		begin
			case (width)
				1:       orgAddrW = 14;
				2:       orgAddrW = 13;
				4:       orgAddrW = 12;
				9:       orgAddrW = 11;
				18:      orgAddrW = 10;
				36:      orgAddrW = 9;
				default: orgAddrW = 14;
			endcase
		end
	endfunction

	function [2:0] codeOf;
		input integer index;
		begin
			codeOf = index[2:0];
		end
	endfunction

	function [31:0] strobeMerge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer b;
		begin
			strobeMerge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b]) begin
					strobeMerge[b*8 +: 8] = data[b*8 +: 8];
				end
			end
		end
	endfunction

	localparam ADDR_W  = clog2(DEPTH);
	localparam BLK_AW  = orgAddrW(DATA_W);
	localparam BLK_CAP = (1 << BLK_AW) * DATA_W;
	localparam TW      = DATA_W * WIDTH_BLOCKS;
	localparam [1:0] CTRL_RST = `BRO_CTRL_RESET;
	localparam NB      = DEPTH_BLOCKS * WIDTH_BLOCKS;
	localparam [31:0] LASTHI_MASK = (TW > 32) ? ((TW >= 64) ? 32'hFFFFFFFF :
		((32'h00000001 << (TW - 32)) - 32'h00000001)) : 32'h00000000;

	// chip-wide set/reset, filtered pin
	reg gsrMeta;
	reg gsrSyncA;
	reg gsrSyncB;
	reg gsrLevel;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			gsrMeta  <= 1'b0;
			gsrSyncA <= 1'b0;
			gsrSyncB <= 1'b0;
			gsrLevel <= 1'b0;
		end else begin
			gsrMeta  <= chipwideSetReset;
			gsrSyncA <= gsrMeta;
			gsrSyncB <= gsrSyncA;
			if (gsrSyncA == gsrSyncB) begin
				gsrLevel <= gsrSyncB;
			end
		end
	end

	wire clearReq = romReset | ((GSR_ENABLE != 0) & gsrLevel);
	wire pipeRstN = reset_n & ~((SYNC_RESET == 0) & clearReq);
	wire syncClr  = (SYNC_RESET != 0) & clearReq;

	// register file state
	reg        lockBit;
	reg        autoInc;
	reg [31:0] loadAddr;
	reg [31:0] loadHi;
	reg [31:0] readCnt;
	reg [31:0] lastLo;
	reg [31:0] lastHi;
	reg [31:0] lastAddr;
	reg        lastHit;

	// apb decode
	wire setupPh = psel & ~penable;
	wire accessPh = psel & penable;
	wire wrAcc = accessPh & pwrite;
	wire [7:0] ofs = paddr[7:0];
	wire upperZero = (APB_AW > 8) ? (paddr >> 8) == 0 : 1'b1;
	reg  mapped;
	reg  loadReg;

	always @* begin
		mapped  = 1'b0;
		loadReg = 1'b0;
		if (upperZero) begin
			case (ofs)
				`BRO_OFS_CTRL, `BRO_OFS_STATUS, `BRO_OFS_READCNT,
				`BRO_OFS_LASTLO, `BRO_OFS_LASTHI, `BRO_OFS_LASTADDR: mapped = 1'b1;
				`BRO_OFS_LOADADDR, `BRO_OFS_LOADLO, `BRO_OFS_LOADHI: begin
					mapped  = 1'b1;
					loadReg = 1'b1;
				end
				default: mapped = 1'b0;
			endcase
		end
	end

	assign pready  = 1'b1;
	assign pslverr = accessPh & (~mapped | (pwrite & loadReg & lockBit));

	wire wrOk = wrAcc & mapped & ~(loadReg & lockBit);
	wire loadCommit = wrOk & (ofs == `BRO_OFS_LOADLO) & ~lockBit;
	wire [63:0] loadWord64 = {loadHi, strobeMerge(32'h00000000, pwdata, pstrb)};
	wire [ADDR_W-1:0] loadLoc = loadAddr[ADDR_W-1:0];
	wire [2:0] loadBank = loadAddr[ADDR_W+2:ADDR_W];

	// cascaded blocks
	wire [NB*DATA_W-1:0] blkWord;
	wire [DEPTH_BLOCKS-1:0] blkHit;

	genvar d;
	genvar w;
	generate
		for (d = 0; d < DEPTH_BLOCKS; d = d + 1) begin : gDepth
			for (w = 0; w < WIDTH_BLOCKS; w = w + 1) begin : gWidth
				wire hitW;
				wire [2:0] code = (DEPTH_BLOCKS == 1) ? BANK_CODE : codeOf(d);
				bro_ebr #(
					.DATA_W    (DATA_W),
					.ADDR_W    (ADDR_W),
					.BANK_CODE ((DEPTH_BLOCKS == 1) ? BANK_CODE : codeOf(d)),
					.OUT_REG   (OUT_REG)
				) uBlock (
					.mclk     (mclk),
					.rstN     (pipeRstN),
					.syncClr  (syncClr),
					.clkGate  (outputClockGate),
					.location (locationBus),
					.bankSel  (bankSelect),
					.loadEn   (loadCommit & (loadBank == code)),
					.loadAddr (loadLoc),
					.loadData (loadWord64[w*DATA_W +: DATA_W]),
					.readWord (blkWord[(d*WIDTH_BLOCKS+w)*DATA_W +: DATA_W]),
					.hit      (hitW)
				);
				if (w == 0) begin : gHit
					assign blkHit[d] = hitW;
				end
			end
		end
	endgenerate

	// only the selected depth row drives non-zero data
	reg [TW-1:0] combined;
	integer i;
	integer j;
	always @* begin
		combined = {TW{1'b0}};
		for (i = 0; i < DEPTH_BLOCKS; i = i + 1) begin
			for (j = 0; j < WIDTH_BLOCKS; j = j + 1) begin
				combined[j*DATA_W +: DATA_W] = combined[j*DATA_W +: DATA_W] |
					blkWord[(i*WIDTH_BLOCKS+j)*DATA_W +: DATA_W];
			end
		end
	end

	assign readWord = combined;

	wire anyHit = |blkHit;
	wire [63:0] combined64 = {{(64-TW){1'b0}}, combined};

	// control, load and observation registers
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lockBit  <= 1'b0;
			autoInc  <= CTRL_RST[`BRO_CTRL_AUTOINC];
			loadAddr <= `BRO_LOADADDR_RESET;
			loadHi   <= `BRO_LOADHI_RESET;
			readCnt  <= `BRO_READCNT_RESET;
			lastLo   <= 32'h00000000;
			lastHi   <= 32'h00000000;
			lastAddr <= 32'h00000000;
			lastHit  <= 1'b0;
		end else begin
			if (wrOk && ofs == `BRO_OFS_CTRL) begin
				if (pstrb[0]) begin
					lockBit <= lockBit | pwdata[`BRO_CTRL_LOCK];
					autoInc <= pwdata[`BRO_CTRL_AUTOINC];
				end
			end
			if (wrOk && ofs == `BRO_OFS_LOADADDR) begin
				loadAddr <= strobeMerge(loadAddr, pwdata, pstrb);
			end else if (loadCommit && autoInc) begin
				loadAddr <= loadAddr + 32'h00000001;
			end
			if (wrOk && ofs == `BRO_OFS_LOADHI) begin
				loadHi <= strobeMerge(loadHi, pwdata, pstrb);
			end
			if (outputClockGate && anyHit) begin
				readCnt <= (wrOk && ofs == `BRO_OFS_READCNT) ?
					32'h00000001 : readCnt + 32'h00000001;
			end else if (wrOk && ofs == `BRO_OFS_READCNT) begin
				readCnt <= 32'h00000000;
			end
			if (outputClockGate) begin
				lastAddr <= {{(29-ADDR_W){1'b0}}, bankSelect, locationBus};
				lastHit  <= anyHit;
			end
			lastLo <= combined64[31:0];
			lastHi <= combined64[63:32] & LASTHI_MASK;
		end
	end

	// read data is latched in the setup cycle
	reg [31:0] next_prdata;
	always @* begin
		next_prdata = 32'h00000000;
		if (upperZero) begin
			case (ofs)
				`BRO_OFS_CTRL: begin
					next_prdata[`BRO_CTRL_LOCK]    = lockBit;
					next_prdata[`BRO_CTRL_AUTOINC] = autoInc;
				end
				`BRO_OFS_STATUS: begin
					next_prdata[`BRO_ST_LOCK]    = lockBit;
					next_prdata[`BRO_ST_REGISTERED_OUTPUT]  = (OUT_REG != 0);
					next_prdata[`BRO_ST_SYNC]    = (SYNC_RESET != 0);
					next_prdata[`BRO_ST_GSREN]   = (GSR_ENABLE != 0);
					next_prdata[`BRO_ST_GSRACT]  = gsrLevel;
					next_prdata[`BRO_ST_LASTHIT] = lastHit;
					next_prdata[`BRO_ST_BANK_LSB +: 3] = BANK_CODE;
					next_prdata[`BRO_ST_DEPTHB_LSB +: 4] = DEPTH_BLOCKS[3:0];
					next_prdata[`BRO_ST_WIDTHB_LSB +: 4] = WIDTH_BLOCKS[3:0];
				end
				`BRO_OFS_LOADADDR: next_prdata = loadAddr;
				`BRO_OFS_LOADHI:   next_prdata = loadHi;
				`BRO_OFS_READCNT:  next_prdata = readCnt;
				`BRO_OFS_LASTLO:   next_prdata = lastLo;
				`BRO_OFS_LASTHI:   next_prdata = lastHi;
				`BRO_OFS_LASTADDR: next_prdata = lastAddr;
				default:           next_prdata = 32'h00000000;
			endcase
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
		end else if (setupPh && !pwrite) begin
			prdata <= next_prdata;
		end
	end

endmodule // bro_rom

// >>> tb/bro_rom_sva.sv
module bro_rom_sva #(
	parameter DATA_W       = 1,
	parameter DEPTH        = 16384,
	parameter WIDTH_BLOCKS = 1,
	parameter APB_AW       = 8,
	parameter OUT_REG      = 0,
	parameter SYNC_RESET   = 0
) (
	input logic                           mclk,
	input logic                           reset_n,
	input logic [$clog2(DEPTH)-1:0]       locationBus,
	input logic [2:0]                     bankSelect,
	input logic                           outputClockGate,
	input logic                           romReset,
	input logic                           chipwideSetReset,
	input logic [DATA_W*WIDTH_BLOCKS-1:0] readWord,
	input logic                           psel,
	input logic                           penable,
	input logic                           pwrite,
	input logic [APB_AW-1:0]              paddr,
	input logic [31:0]                    pwdata,
	input logic [3:0]                     pstrb,
	input logic [31:0]                    prdata,
	input logic                           pready,
	input logic                           pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	property p_ready;
		pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err_idle;
		!(psel && penable) |-> !pslverr;
	endproperty
	a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
	property p_unm;
		psel && penable && paddr == 8'h24 |-> pslverr;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped not refused");
	property p_unm_rd;
		psel && penable && !pwrite && paddr == 8'h24 |-> prdata == 32'h0;
	endproperty
	a_unm_rd: assert property (p_unm_rd) else $error("unmapped read not zero");
	property p_status;
		psel && penable && !pwrite && paddr == 8'h04 |-> !pslverr && prdata[1] == (OUT_REG != 0);
	endproperty
	a_status: assert property (p_status) else $error("status output mode wrong");
	property p_clr;
		romReset && SYNC_RESET == 0 |-> readWord == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("clear left data");
	property p_clr_next;
		romReset |=> readWord == '0;
	endproperty
	a_clr_next: assert property (p_clr_next) else $error("clear not seen next cycle");
	property p_hold;
		!outputClockGate && !romReset ##1 !romReset |-> $stable(readWord);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved while gated off");
	property p_miss;
		outputClockGate && bankSelect != 3'h0 ##1 outputClockGate |=> readWord == '0;
	endproperty
	a_miss: assert property (p_miss) else $error("foreign bank answered");
	property p_lat;
		$changed(readWord) && !romReset |-> $past(outputClockGate);
	endproperty
	a_lat: assert property (p_lat) else $error("data changed without gated edge");
endmodule // bro_rom_sva

bind bro_rom bro_rom_sva #(.DATA_W(DATA_W), .DEPTH(DEPTH), .WIDTH_BLOCKS(WIDTH_BLOCKS),
	.APB_AW(APB_AW), .OUT_REG(OUT_REG), .SYNC_RESET(SYNC_RESET)) u_sva (.mclk, .reset_n,
	.locationBus, .bankSelect, .outputClockGate,
	.romReset, .chipwideSetReset, .readWord, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr);

// >>> tb/bro_fabric_model.sv
module bro_fabric_model (
	input  logic        mclk,
	output logic [11:0] locationBus,
	output logic [2:0]  bankSelect,
	output logic        outputClockGate
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		locationBus = 12'h000;
		bankSelect = 3'h0;
		outputClockGate = 1'b0;
	end
	// one group of blocks only, no outside decode
	task automatic issue(input logic [11:0] loc, input logic [2:0] bank);
		@(posedge mclk);
		locationBus <= loc;
		bankSelect <= bank;
		outputClockGate <= 1'b1;
	endtask
	// gate off, location scrambled
	task automatic idle;
		@(posedge mclk);
		locationBus <= ~locationBus;
		outputClockGate <= 1'b0;
	endtask
endmodule // bro_fabric_model

// >>> tb/tb_top.sv
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0;
	logic        reset_n = 0;
	logic        romReset = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [11:0] locationBus;
	wire  [2:0]  bankSelect;
	wire         outputClockGate;
	wire  [3:0]  readWord;
	int          error_cnt = 0;
	int          tests_run = 0;
	logic [31:0] rd;
	logic        err;
	logic [11:0] locTab [4] = '{12'h000, 12'h001, 12'hAAA, 12'hFFF};
	logic [3:0]  valTab [4] = '{4'hA, 4'h5, 4'hF, 4'h3};
	initial forever #2 mclk = ~mclk;
	bro_fabric_model fab (.mclk, .locationBus, .bankSelect, .outputClockGate);
	bro_rom #(.DATA_W(4), .DEPTH(4096), .OUT_REG(1)) DUT (.mclk, .reset_n, .locationBus,
		.bankSelect, .outputClockGate, .romReset, .chipwideSetReset(1'b0), .readWord, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr);
	task automatic wrap_up;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic fetch(input logic [11:0] loc, input logic [2:0] bank);
		fab.issue(loc, bank);
		@(posedge mclk);
		fab.idle();
		#1;
	endtask
	task automatic s_load_read;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h08, {20'h0, locTab[i]});
			apb(1'b1, 8'h0C, {28'h0, valTab[i]});
		end
		apb(1'b1, 8'h00, 32'h3);
		for (int i = 0; i < 4; i++) begin
			fab.issue(locTab[i], 3'h0);
			@(posedge mclk);
			#1 `CHK("early", (i == 0) ? 4'h0 : valTab[i - 1], readWord)
			fab.idle();
			#1 `CHK("word", valTab[i], readWord)
		end
	endtask
	task automatic s_hold_miss;
		repeat (4) @(posedge mclk);
		#1 `CHK("hold", valTab[3], readWord)
		fetch(locTab[0], 3'h5);
		`CHK("miss", 4'h0, readWord)
	endtask
	task automatic s_clear;
		fetch(locTab[2], 3'h0);
		@(posedge mclk);
		romReset <= 1'b1;
		#1 `CHK("clear", 4'h0, readWord)
		@(posedge mclk);
		romReset <= 1'b0;
		fetch(locTab[2], 3'h0);
		`CHK("kept", valTab[2], readWord)
	endtask
	task automatic s_regs;
		apb(1'b1, 8'h0C, 32'h0);
		`CHK("lockerr", 1'b1, err)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("unmerr", 1'b1, err)
		`CHK("unmdata", 32'h0, rd)
		apb(1'b0, 8'h04, 32'h0);
		`CHK("status", 2'h3, rd[1:0])
		apb(1'b0, 8'h08, 32'h0);
		`CHK("autoinc", 32'h00001000, rd)
		apb(1'b1, 8'h14, 32'h0);
		fetch(locTab[1], 3'h0);
		`CHK("locked", valTab[1], readWord)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("readcnt", 32'h00000002, rd)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("lastaddr", {20'h0, locTab[1]}, rd)
		apb(1'b0, 8'h18, 32'h0);
		`CHK("lastlo", {28'h0, valTab[1]}, rd)
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		s_load_read();
		s_hold_miss();
		s_clear();
		s_regs();
		wrap_up();
	end
endmodule // tb_top
